//--- hw/lbcp_top.sv
// brightness path: registers, pwm sampler, mode mixer, ramper, timeout
// assumes sink voltages come from logic on core_clk; pwm_in is a pin
`timescale 1ns/100ps
module lbcp_top #(
   parameter int TMO0_US = lbcp_pkg::LBCP_TMO0_US,
   parameter int TMO1_US = lbcp_pkg::LBCP_TMO1_US,
   parameter int TMO2_US = lbcp_pkg::LBCP_TMO2_US
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // two-wire bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // pwm input pin
   input  wire logic        pwm_in,
   // digitised sink headroom voltages
   input  wire logic [7:0]  sink_one_voltage,
   input  wire logic [7:0]  sink_two_voltage,
   input  wire logic [7:0]  sink_three_voltage,
   // boost and current outputs
   output logic [10:0]      led_current_code,
   output logic             boost_en,
   output logic             boost_freq_sel,
   output logic             boost_freq_shift,
   output logic             min_inductor_sel,
   output logic [7:0]       sink_headroom_voltage
);
   import lbcp_pkg::*;

   logic        wr_stb;
   logic [7:0]  reg_addr, wr_data, rd_data_q;
   logic [7:0]  cfg_q, pwm_cfg_q, bst_q, lo_q, hi_q;
   logic [10:0] brightness_code_q;
   lbcp_mode_t  mode;
   logic [2:0]  ramp_sel, hyst_sel;
   logic [1:0]  rate_sel;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   lbcp_twi_slave u_twi (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_out  (sda_out),
      .sda_oe   (sda_oe),
      .wr_stb   (wr_stb),
      .reg_addr (reg_addr),
      .wr_data  (wr_data),
      .rd_data  (rd_data_q)
   );

   assign mode     = lbcp_mode_t'(cfg_q[LBCP_MODE_LSB +: 2]);
   assign ramp_sel = cfg_q[LBCP_RAMP_LSB +: 3];
   assign rate_sel = pwm_cfg_q[LBCP_RATE_LSB +: 2];
   assign hyst_sel = pwm_cfg_q[LBCP_HYST_LSB +: 3];

   // register writes; brightness code applies on the high byte only
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg_q <= LBCP_CFG_RST; pwm_cfg_q <= LBCP_PWM_RST; bst_q <= LBCP_BST_RST;
         lo_q <= LBCP_BRT_RST; hi_q <= LBCP_BRT_RST; brightness_code_q <= 11'h000;
      end else if (wr_stb) begin
         if (reg_addr == LBCP_CFG_ADDR) cfg_q <= wr_data;
         if (reg_addr == LBCP_PWM_ADDR) pwm_cfg_q <= wr_data;
         if (reg_addr == LBCP_BST_ADDR) bst_q <= wr_data;
         if (reg_addr == LBCP_LO_ADDR) lo_q <= wr_data;
         if (reg_addr == LBCP_HI_ADDR) begin
            hi_q <= wr_data;
            brightness_code_q <= {wr_data, lo_q[2:0]};
         end
      end
   end

   chk_lo_write_holds: assert property (wr_stb && reg_addr == LBCP_LO_ADDR
      |=> $stable(brightness_code_q)) else $error("low write moved code");
   chk_hi_write_apply: assert property (wr_stb && reg_addr == LBCP_HI_ADDR
      |=> brightness_code_q == {$past(wr_data), $past(lo_q[2:0])})
      else $error("high write not applied");

   // boost control bits drive the converter directly
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         boost_freq_sel   <= 1'b0;
         boost_freq_shift <= 1'b0;
         min_inductor_sel <= 1'b0;
      end else begin
         boost_freq_sel   <= bst_q[LBCP_FSEL_BIT];
         boost_freq_shift <= bst_q[LBCP_SHIFT_BIT];
         min_inductor_sel <= bst_q[LBCP_MIND_BIT];
      end
   end

   chk_freq_bits: assert property ($changed(bst_q) |=> boost_freq_sel ==
      $past(bst_q[LBCP_FSEL_BIT]) && boost_freq_shift == $past(bst_q[LBCP_SHIFT_BIT]))
      else $error("boost frequency bits not followed");

   // microsecond tick and pwm sample enable dividers
   logic [6:0] tick_cnt_q, smp_cnt_q, smp_div;
   logic       tick_q, smp_q;
   always_comb begin
      unique case (rate_sel)
         2'b00:   smp_div = 7'(LBCP_SMP0_CYC - 1);
         2'b01:   smp_div = 7'(LBCP_SMP1_CYC - 1);
         default: smp_div = 7'(LBCP_SMP2_CYC - 1);
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tick_cnt_q <= 7'h00; smp_cnt_q <= 7'h00; tick_q <= 1'b0; smp_q <= 1'b0;
      end else begin
         tick_q     <= (tick_cnt_q == 7'(LBCP_TICK_CYC - 1));
         tick_cnt_q <= (tick_cnt_q == 7'(LBCP_TICK_CYC - 1)) ? 7'h00 : tick_cnt_q + 7'h01;
         smp_q      <= (smp_cnt_q >= smp_div);
         smp_cnt_q  <= (smp_cnt_q >= smp_div) ? 7'h00 : smp_cnt_q + 7'h01;
      end
   end

   // pwm pin synchroniser and sampling at the selected rate
   logic pwm_s1_q, pwm_s2_q, pwm_smp_q, pwm_rise;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pwm_s1_q <= 1'b0; pwm_s2_q <= 1'b0; pwm_smp_q <= 1'b0;
      end else begin
         pwm_s1_q <= pwm_in;
         pwm_s2_q <= pwm_s1_q;
         if (smp_q) pwm_smp_q <= pwm_s2_q;
      end
   end
   assign pwm_rise = smp_q & pwm_s2_q & ~pwm_smp_q;

   // period and high-time counts between rising edges
   logic [14:0] per_cnt_q, hi_cnt_q, per_lat_q;
   logic [15:0] rem_q;
   logic [10:0] quo_q;
   logic [3:0]  div_cnt_q;
   logic        seen_q, div_busy_q, div_done_q;
   logic [15:0] rem_sh;
   assign rem_sh = {rem_q[14:0], 1'b0};
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         per_cnt_q <= 15'h0000; hi_cnt_q <= 15'h0000; seen_q <= 1'b0;
      end else if (pwm_rise) begin
         per_cnt_q <= 15'h0001; hi_cnt_q <= 15'h0001; seen_q <= 1'b1;
      end else if (smp_q && per_cnt_q != 15'h7fff) begin
         per_cnt_q <= per_cnt_q + 15'h0001;
         if (pwm_s2_q) hi_cnt_q <= hi_cnt_q + 15'h0001;
      end
   end

   // serial divider: duty code = high * 2048 / period, eleven steps
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rem_q <= 16'h0000; quo_q <= 11'h000; per_lat_q <= 15'h0001;
         div_cnt_q <= 4'h0; div_busy_q <= 1'b0; div_done_q <= 1'b0;
      end else begin
         div_done_q <= 1'b0;
         if (pwm_rise && seen_q && !div_busy_q) begin
            rem_q <= {1'b0, hi_cnt_q}; per_lat_q <= per_cnt_q;
            div_cnt_q <= 4'h0; div_busy_q <= 1'b1;
         end else if (div_busy_q) begin
            if (rem_sh >= {1'b0, per_lat_q}) begin
               rem_q <= rem_sh - {1'b0, per_lat_q};
               quo_q <= {quo_q[9:0], 1'b1};
            end else begin
               rem_q <= rem_sh;
               quo_q <= {quo_q[9:0], 1'b0};
            end
            div_cnt_q <= div_cnt_q + 4'h1;
            if (div_cnt_q == 4'ha) begin
               div_busy_q <= 1'b0;
               div_done_q <= 1'b1;
            end
         end
      end
   end

   // direction hysteresis on the measured duty code
   logic [10:0] pwm_code_q, hyst_thr;
   logic        dir_up_q;
   assign hyst_thr = 11'h001 << hyst_sel;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pwm_code_q <= 11'h000; dir_up_q <= 1'b1;
      end else if (div_done_q) begin
         if (quo_q > pwm_code_q && (dir_up_q || quo_q - pwm_code_q >= hyst_thr)) begin
            pwm_code_q <= quo_q;
            dir_up_q   <= 1'b1;
         end else if (quo_q < pwm_code_q
                      && (!dir_up_q || pwm_code_q - quo_q >= hyst_thr)) begin
            pwm_code_q <= quo_q;
            dir_up_q   <= 1'b0;
         end
      end
   end

   chk_hyst_reverse: assert property (div_done_q && dir_up_q && quo_q < pwm_code_q
      && pwm_code_q - quo_q < hyst_thr |=> $stable(pwm_code_q))
      else $error("reversal passed hysteresis");

   // pwm absence timeout in microsecond ticks
   logic [14:0] tmo_cnt_q, tmo_lim;
   logic        tmo_q, pwm_path_en;
   assign pwm_path_en = (mode != LBCP_BUS_ONLY);
   always_comb begin
      unique case (rate_sel)
         2'b00:   tmo_lim = 15'(TMO0_US);
         2'b01:   tmo_lim = 15'(TMO1_US);
         default: tmo_lim = 15'(TMO2_US);
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tmo_cnt_q <= 15'h0000; tmo_q <= 1'b0;
      end else if (!pwm_path_en || pwm_rise) begin
         tmo_cnt_q <= 15'h0000;
         tmo_q     <= 1'b0;
      end else if (tick_q && !tmo_q) begin
         // flag rises on the tick that brings the count to the limit
         tmo_cnt_q <= tmo_cnt_q + 15'h0001;
         if (tmo_cnt_q + 15'h0001 >= tmo_lim) tmo_q <= 1'b1;
      end
   end

   // boost runs unless the pwm path has timed out
   always_ff @(posedge core_clk) begin
      if (!rst_b) boost_en <= 1'b0;
      else boost_en <= ~tmo_q;
   end

   chk_tmo_limit: assert property ($rose(tmo_q) |-> tmo_cnt_q >= $past(tmo_lim))
      else $error("timeout fired early");
   chk_tmo_boost_off: assert property (tmo_q |=> !boost_en)
      else $error("boost kept running after timeout");
   chk_pulse_resume: assert property (pwm_rise |=> !tmo_q ##1 boost_en)
      else $error("boost not restarted by pulse");
   chk_bus_no_tmo: assert property (mode == LBCP_BUS_ONLY [*2] |-> !tmo_q)
      else $error("timeout while pwm disabled");

   // mode mixer selects the ramp target
   logic [21:0] mul_tgt, mul_out;
   logic [10:0] target, ramp_q;
   assign mul_tgt = brightness_code_q * pwm_code_q;
   assign mul_out = ramp_q * pwm_code_q;
   always_comb begin
      unique case (mode)
         LBCP_BUS_ONLY: target = brightness_code_q;
         LBCP_PWM_ONLY: target = pwm_code_q;
         LBCP_MUL_RAMP: target = mul_tgt[21:11];
         LBCP_RAMP_MUL: target = brightness_code_q;
      endcase
   end

   chk_bus_target: assert property (mode == LBCP_BUS_ONLY |-> target == brightness_code_q)
      else $error("pwm leaked into bus mode");
   chk_pwm_target: assert property (mode == LBCP_PWM_ONLY |-> target == pwm_code_q)
      else $error("pwm mode target wrong");

   // ramper: one code step per programmed number of microseconds
   logic [7:0] step_tmr_q;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ramp_q <= 11'h000; step_tmr_q <= 8'h00;
      end else if (tick_q) begin
         if (step_tmr_q != 8'h00) step_tmr_q <= step_tmr_q - 8'h01;
         else if (ramp_q != target) begin
            ramp_q     <= (ramp_q < target) ? ramp_q + 11'h001 : ramp_q - 11'h001;
            step_tmr_q <= (8'h01 << ramp_sel) - 8'h01;
         end
      end
   end

   chk_ramp_one_code: assert property ($changed(ramp_q) |->
      ramp_q == $past(ramp_q) + 11'h001 || ramp_q == $past(ramp_q) - 11'h001)
      else $error("ramper skipped codes");
   chk_ramp_spacing: assert property ($changed(ramp_q) |=> $stable(ramp_q) [*8])
      else $error("ramp steps too close");

   // led current code; mode 11 scales the ramper output without ramping
   always_ff @(posedge core_clk) begin
      if (!rst_b) led_current_code <= 11'h000;
      else if (mode == LBCP_RAMP_MUL) led_current_code <= mul_out[21:11];
      else led_current_code <= ramp_q;
   end

   chk_scale_output: assert property (mode == LBCP_RAMP_MUL && $stable(ramp_q)
      && $stable(pwm_code_q) |=> ##1 led_current_code <= ramp_q)
      else $error("scaled code above ramper");

   // boost regulates on the lowest sink headroom
   always_ff @(posedge core_clk) begin
      if (!rst_b) sink_headroom_voltage <= 8'h00;
      else if (sink_one_voltage <= sink_two_voltage && sink_one_voltage <= sink_three_voltage)
         sink_headroom_voltage <= sink_one_voltage;
      else if (sink_two_voltage <= sink_three_voltage)
         sink_headroom_voltage <= sink_two_voltage;
      else sink_headroom_voltage <= sink_three_voltage;
   end

   chk_headroom_min: assert property (1'b1 |=> sink_headroom_voltage <= $past(sink_one_voltage)
      && sink_headroom_voltage <= $past(sink_two_voltage)
      && sink_headroom_voltage <= $past(sink_three_voltage))
      else $error("headroom not the minimum");

   // read data: stored bytes plus live path state
   always_ff @(posedge core_clk) begin
      if (!rst_b) rd_data_q <= 8'h00;
      else begin
         unique case (reg_addr)
            LBCP_CFG_ADDR:  rd_data_q <= cfg_q;
            LBCP_PWM_ADDR:  rd_data_q <= pwm_cfg_q;
            LBCP_BST_ADDR:  rd_data_q <= bst_q;
            LBCP_LO_ADDR:   rd_data_q <= lo_q;
            LBCP_HI_ADDR:   rd_data_q <= hi_q;
            LBCP_STAT_ADDR: rd_data_q <= {5'h00, dir_up_q, boost_en, tmo_q};
            LBCP_CODE_ADDR: rd_data_q <= led_current_code[10:3];
            default:        rd_data_q <= 8'h00;
         endcase
      end
   end
endmodule

//--- include/lbcp_pkg.sv
// constants and types shared by the led brightness control path
// assumes a 100 MHz core clock and register access over a two-wire slave
package lbcp_pkg;
   // register offsets
   localparam logic [7:0] LBCP_CFG_ADDR  = 8'h11;
   localparam logic [7:0] LBCP_PWM_ADDR  = 8'h12;
   localparam logic [7:0] LBCP_BST_ADDR  = 8'h13;
   localparam logic [7:0] LBCP_LO_ADDR   = 8'h18;
   localparam logic [7:0] LBCP_HI_ADDR   = 8'h19;
   localparam logic [7:0] LBCP_STAT_ADDR = 8'h1a;
   localparam logic [7:0] LBCP_CODE_ADDR = 8'h1b;
   // field positions
   localparam int LBCP_MODE_LSB  = 5;
   localparam int LBCP_RAMP_LSB  = 2;
   localparam int LBCP_RATE_LSB  = 6;
   localparam int LBCP_HYST_LSB  = 2;
   localparam int LBCP_MIND_BIT  = 4;
   localparam int LBCP_FSEL_BIT  = 5;
   localparam int LBCP_SHIFT_BIT = 6;
   // reset values
   localparam logic [7:0] LBCP_CFG_RST = 8'h00;
   localparam logic [7:0] LBCP_PWM_RST = 8'h00;
   localparam logic [7:0] LBCP_BST_RST = 8'h00;
   localparam logic [7:0] LBCP_BRT_RST = 8'h00;
   // timing: one microsecond tick and the three pwm sample rates
   localparam int LBCP_CLK_NS    = 10;
   localparam int LBCP_TICK_NS   = 1000;
   localparam int LBCP_TICK_CYC  = LBCP_TICK_NS / LBCP_CLK_NS;
   localparam int LBCP_CLK_KHZ   = 1000000 / LBCP_CLK_NS;
   localparam int LBCP_SMP0_KHZ  = 800;
   localparam int LBCP_SMP1_KHZ  = 4000;
   localparam int LBCP_SMP2_KHZ  = 24000;
   localparam int LBCP_SMP0_CYC  = LBCP_CLK_KHZ / LBCP_SMP0_KHZ;
   localparam int LBCP_SMP1_CYC  = LBCP_CLK_KHZ / LBCP_SMP1_KHZ;
   localparam int LBCP_SMP2_CYC  = LBCP_CLK_KHZ / LBCP_SMP2_KHZ;
   // pwm absence timeouts in microsecond ticks
   localparam int LBCP_TMO0_US   = 25000;
   localparam int LBCP_TMO1_US   = 3000;
   localparam int LBCP_TMO2_US   = 600;
   // two-wire slave address
   localparam logic [6:0] LBCP_DEV_ADDR = 7'h36;
   // brightness modes
   typedef enum logic [1:0] {
      LBCP_BUS_ONLY = 2'b00,
      LBCP_PWM_ONLY = 2'b01,
      LBCP_MUL_RAMP = 2'b10,
      LBCP_RAMP_MUL = 2'b11
   } lbcp_mode_t;
endpackage

//--- hw/lbcp_twi_slave.sv
// two-wire register slave: byte pointer, burst write and burst read
// assumes scl and sda arrive asynchronously; sda is open drain
`timescale 1ns/100ps
module lbcp_twi_slave (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // bus pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // register side
   output logic            wr_stb,
   output logic [7:0]      reg_addr,
   output logic [7:0]      wr_data,
   input  wire logic [7:0] rd_data
);
   import lbcp_pkg::*;

   typedef enum logic [3:0] {
      LBCP_IDLE = 4'b0000, LBCP_ADDR = 4'b0001, LBCP_AACK = 4'b0011,
      LBCP_REG  = 4'b0010, LBCP_RACK = 4'b0110, LBCP_WDAT = 4'b0111,
      LBCP_WACK = 4'b0101, LBCP_RDAT = 4'b0100, LBCP_DACK = 4'b1100
   } lbcp_twi_t;

   lbcp_twi_t   st_q;
   logic [2:0]  scl_q, sda_q;
   logic [7:0]  sh_q;
   logic [3:0]  cnt_q;
   logic        rw_q, nack_q, start_w, stop_w, rise_w, fall_w;

   // two-flop synchronisers plus one history stage for edges
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], scl_in};
         sda_q <= {sda_q[1:0], sda_in};
      end
   end

   assign start_w = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   assign stop_w  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   assign rise_w  = scl_q[1] & ~scl_q[2];
   assign fall_w  = ~scl_q[1] & scl_q[2];

   // protocol sequencer
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_q <= LBCP_IDLE; sh_q <= 8'h00; cnt_q <= 4'h0;
         rw_q <= 1'b0; nack_q <= 1'b0; sda_oe <= 1'b0; sda_out <= 1'b0;
         wr_stb <= 1'b0; reg_addr <= 8'h00; wr_data <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (stop_w) begin
            st_q   <= LBCP_IDLE;
            sda_oe <= 1'b0;
         end else if (start_w) begin
            st_q   <= LBCP_ADDR;
            cnt_q  <= 4'h0;
            sda_oe <= 1'b0;
         end else if (rise_w) begin
            if (st_q == LBCP_ADDR || st_q == LBCP_REG || st_q == LBCP_WDAT) begin
               sh_q  <= {sh_q[6:0], sda_q[1]};
               cnt_q <= cnt_q + 4'h1;
            end
            if (st_q == LBCP_DACK) nack_q <= sda_q[1];
         end else if (fall_w) begin
            unique case (st_q)
               LBCP_IDLE: ;
               LBCP_ADDR: if (cnt_q == 4'h8) begin
                  if (sh_q[7:1] == LBCP_DEV_ADDR) begin
                     st_q <= LBCP_AACK; sda_oe <= 1'b1; rw_q <= sh_q[0];
                  end else st_q <= LBCP_IDLE;
               end
               LBCP_AACK: begin
                  cnt_q <= 4'h1;
                  if (rw_q) begin
                     st_q <= LBCP_RDAT; sh_q <= rd_data; sda_oe <= ~rd_data[7];
                  end else begin
                     st_q <= LBCP_REG; cnt_q <= 4'h0; sda_oe <= 1'b0;
                  end
               end
               LBCP_REG: if (cnt_q == 4'h8) begin
                  reg_addr <= sh_q; st_q <= LBCP_RACK; sda_oe <= 1'b1;
               end
               LBCP_RACK, LBCP_WACK: begin
                  if (st_q == LBCP_WACK) reg_addr <= reg_addr + 8'h01;
                  st_q <= LBCP_WDAT; cnt_q <= 4'h0; sda_oe <= 1'b0;
               end
               LBCP_WDAT: if (cnt_q == 4'h8) begin
                  wr_stb <= 1'b1; wr_data <= sh_q; st_q <= LBCP_WACK; sda_oe <= 1'b1;
               end
               LBCP_RDAT: if (cnt_q == 4'h8) begin
                  st_q <= LBCP_DACK; sda_oe <= 1'b0; reg_addr <= reg_addr + 8'h01;
               end else begin
                  sda_oe <= ~sh_q[6]; sh_q <= {sh_q[6:0], 1'b0}; cnt_q <= cnt_q + 4'h1;
               end
               LBCP_DACK: if (nack_q) st_q <= LBCP_IDLE;
               else begin
                  st_q <= LBCP_RDAT; sh_q <= rd_data; sda_oe <= ~rd_data[7]; cnt_q <= 4'h1;
               end
               default: st_q <= LBCP_IDLE;
            endcase
         end
      end
   end
endmodule

//--- test/lbcp_host_model.sv
// partner model: two-wire host that writes and reads registers, plus a pwm source
// assumes the bench forms the sda wire as a pulled-up wired-and
`timescale 1ns/100ps
module lbcp_host_model (
   // clock
   input  wire logic core_clk,
   // bus and pwm pins
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_drv,
   output logic      pwm,
   // set when any byte of the last write went unacknowledged
   output logic      nack
);
   import lbcp_pkg::*;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      pwm = 1'b0;
      nack = 1'b0;
   end
   // a quarter bit time, long against the device's synchronisers
   task automatic q();
      repeat (10) @(posedge core_clk);
   endtask
   // data changes only while scl is low; ack sampled while scl is high
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= -1; i--) begin
         q();
         sda_drv <= (i < 0) ? 1'b1 : b[i];
         q();
         scl <= 1'b1;
         q();
         if (i < 0 && sda_wire !== 1'b0) nack <= 1'b1;
         q();
         scl <= 1'b0;
      end
   endtask
   // start from idle, address with write, then the register pointer
   task automatic wr_hdr(input logic [7:0] a);
      nack <= 1'b0;
      q();
      sda_drv <= 1'b0;
      q();
      scl <= 1'b0;
      put_byte({LBCP_DEV_ADDR, 1'b0});
      put_byte(a);
   endtask
   // stop condition, then a quarter bit of idle
   task automatic bus_stop();
      q();
      sda_drv <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      sda_drv <= 1'b1;
      q();
   endtask
   // start, address, pointer, one data byte, stop
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      wr_hdr(a);
      put_byte(d);
      bus_stop();
   endtask
   // pointer write, repeated start, one byte read and refused, stop
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      wr_hdr(a);
      q();
      sda_drv <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      sda_drv <= 1'b0;
      q();
      scl <= 1'b0;
      put_byte({LBCP_DEV_ADDR, 1'b1});
      // sda stays released: data bits, then a refusing ack bit
      for (int i = 7; i >= -1; i--) begin
         q();
         q();
         scl <= 1'b1;
         q();
         if (i >= 0) d[i] = sda_wire;
         q();
         scl <= 1'b0;
      end
      bus_stop();
   endtask
   // pwm periods well above the minimum frequency of every sample rate
   task automatic pwm_run(input int n, input int hi, input int per);
      repeat (n) begin
         pwm <= 1'b1;
         repeat (hi) @(posedge core_clk);
         pwm <= 1'b0;
         repeat (per - hi) @(posedge core_clk);
      end
   endtask
endmodule

//--- test/lbcp_top_tb_top.sv
// testbench for the brightness path: bus writes, ramp, headroom, pwm timeout
// assumes timeouts shortened to tens of microseconds through parameters
`timescale 1ns/100ps
module lbcp_top_tb_top;
   import lbcp_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        scl, sda_drv, pwm, nack, sda_oe;
   logic [7:0]  v1 = 8'h40, v2 = 8'h40, v3 = 8'h40, hr;
   logic [10:0] code;
   logic [7:0]  rd;
   logic        ben, fsel, fshift, mind;
   int          n_errors = 0, cmp_count = 0, cyc = 0;
   wire         sda = sda_drv & ~sda_oe;
   always #5 core_clk = ~core_clk;
   lbcp_top #(.TMO0_US(40), .TMO1_US(20), .TMO2_US(10)) lbcp_top_i (
      .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .pwm_in(pwm), .sink_one_voltage(v1),
      .sink_two_voltage(v2), .sink_three_voltage(v3), .led_current_code(code),
      .boost_en(ben), .boost_freq_sel(fsel), .boost_freq_shift(fshift),
      .min_inductor_sel(mind), .sink_headroom_voltage(hr));
   lbcp_host_model lbcp_host_model_i (
      .core_clk(core_clk), .sda_wire(sda), .scl(scl), .sda_drv(sda_drv),
      .pwm(pwm), .nack(nack));
   // one comparison, counted, reported at once on a mismatch
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // cut a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // boost control bits follow register 0x13
   task automatic t_boost();
      lbcp_host_model_i.wr_reg(LBCP_BST_ADDR, 8'h70);
      repeat (4) @(posedge core_clk);
      chk(11'({fshift, fsel, mind}), 11'h007);
      lbcp_host_model_i.wr_reg(LBCP_BST_ADDR, 8'h20);
      repeat (4) @(posedge core_clk);
      chk(11'({fshift, fsel, mind, nack}), 11'h004);
   endtask
   // low bits alone change nothing; high byte write ramps to the new code
   task automatic t_bus_code();
      lbcp_host_model_i.wr_reg(LBCP_LO_ADDR, 8'h07);
      repeat (300) @(posedge core_clk);
      chk(code, 11'h000);
      lbcp_host_model_i.wr_reg(LBCP_HI_ADDR, 8'h01);
      repeat (500) @(posedge core_clk);
      chk(11'(code < 11'h00f), 11'h001);
      repeat (2500) @(posedge core_clk);
      chk(code, 11'h00f);
      chk(11'(ben), 11'h001);
      lbcp_host_model_i.rd_reg(LBCP_CODE_ADDR, rd);
      chk(11'(rd), 11'h001);
   endtask
   // regulation point is the lowest of the three sinks
   task automatic t_headroom();
      v1 <= 8'h30;
      v2 <= 8'h10;
      v3 <= 8'h20;
      repeat (3) @(posedge core_clk);
      chk(11'(hr), 11'h010);
      v3 <= 8'h05;
      repeat (3) @(posedge core_clk);
      chk(11'(hr), 11'h005);
   endtask
   // pwm only at the fastest rate: duty 1/8, then absence and return
   task automatic t_pwm();
      lbcp_host_model_i.wr_reg(LBCP_PWM_ADDR, 8'h80);
      lbcp_host_model_i.wr_reg(LBCP_CFG_ADDR, 8'h20);
      lbcp_host_model_i.pwm_run(80, 50, 400);
      chk(11'(code > 11'd200 && code < 11'd300), 11'h001);
      chk(11'(ben), 11'h001);
      repeat (2000) @(posedge core_clk);
      chk(11'(ben), 11'h000);
      lbcp_host_model_i.pwm_run(3, 50, 400);
      chk(11'(ben), 11'h001);
   endtask
   // modes 10 and 11 at 50 % duty, direct scaling, hysteresis, status readback
   task automatic t_mix();
      fork
         lbcp_host_model_i.pwm_run(12, 200, 400);
         begin
            lbcp_host_model_i.wr_reg(LBCP_HI_ADDR, 8'h40);
            lbcp_host_model_i.wr_reg(LBCP_CFG_ADDR, 8'h40);
         end
      join
      chk(code, 11'd259);
      fork
         lbcp_host_model_i.pwm_run(12, 200, 400);
         begin
            lbcp_host_model_i.wr_reg(LBCP_HI_ADDR, 8'h20);
            lbcp_host_model_i.wr_reg(LBCP_CFG_ADDR, 8'h60);
         end
      join
      chk(code, 11'd131);
      lbcp_host_model_i.pwm_run(3, 100, 400);
      chk(code, 11'd65);
      fork
         lbcp_host_model_i.pwm_run(4, 100, 400);
         lbcp_host_model_i.wr_reg(LBCP_PWM_ADDR, 8'h94);
      join
      lbcp_host_model_i.pwm_run(3, 104, 400);
      chk(code, 11'd65);
      repeat (1500) @(posedge core_clk);
      lbcp_host_model_i.rd_reg(LBCP_STAT_ADDR, rd);
      chk(11'(rd[1:0]), 11'h001);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      chk(11'(ben), 11'h000);
      rst_b <= 1'b1;
      repeat (10) @(posedge core_clk);
      t_boost();
      t_bus_code();
      t_headroom();
      t_pwm();
      t_mix();
      tally_and_finish();
   end
endmodule
